// *** verilog/sfp_pkg.sv ***
package sfp_pkg;

	// Special function register offsets on the core's register port.
	localparam logic [7:0] SFP_ADDR_DPL  = 8'h82;
	localparam logic [7:0] SFP_ADDR_DPH  = 8'h83;
	localparam logic [7:0] SFP_ADDR_PWR_CTRL = 8'h87;
	localparam logic [7:0] SFP_ADDR_AUX1     = 8'ha2;
	localparam logic [7:0] SFP_ADDR_STATUS   = 8'hd0;

	// Field positions inside the status word.
	localparam int SFP_ST_CARRY   = 7;
	localparam int SFP_ST_AUX     = 6;
	localparam int SFP_ST_USER0   = 5;
	localparam int SFP_ST_BANK_HI = 4;
	localparam int SFP_ST_BANK_LO = 3;
	localparam int SFP_ST_OVF     = 2;
	localparam int SFP_ST_USER1   = 1;
	localparam int SFP_ST_PAR     = 0;

	// Field positions inside power control and aux function one.
	localparam int SFP_PWR_FLAG_HI = 3;
	localparam int SFP_PWR_FLAG_LO = 2;
	localparam int SFP_AUX1_SEL    = 0;

	// Reset values.
	localparam logic [7:0]  SFP_RST_STATUS = 8'h00;
	localparam logic [1:0]  SFP_RST_GF     = 2'h0;
	localparam logic        SFP_RST_SEL    = 1'b0;
	localparam logic [15:0] SFP_RST_PTR    = 16'h0000;

	// Working register bank geometry.
	localparam logic [4:0] SFP_BANK_BASE = 5'h00;

	// Flag-affecting operations presented by the core each cycle.
	typedef enum logic [3:0] {
		SFP_OP_NONE,
		SFP_OP_ADD,
		SFP_OP_ADDC,
		SFP_OP_SUBB,
		SFP_OP_MUL,
		SFP_OP_DIV,
		SFP_OP_DA,
		SFP_OP_SETC,
		SFP_OP_CLRC,
		SFP_OP_CARRY
	} sfp_op_e;

endpackage : sfp_pkg

// *** verilog/sfp_arith_flags.sv ***
// Combinational flag evaluation for the arithmetic operations.
module sfp_arith_flags
	import sfp_pkg::*;
(
	input  wire sfp_op_e    op_i,
	input  wire logic [7:0] acc_i,
	input  wire logic [7:0] opnd_i,
	input  wire logic       carry_i,
	input  wire logic [7:0] divisor_i,
	output logic            upd_carry_o,
	output logic            upd_aux_o,
	output logic            upd_ovf_o,
	output logic            carry_o,
	output logic            aux_o,
	output logic            ovf_o
);

	logic [8:0]  sum7;
	logic [7:0]  sum6;
	logic [4:0]  sum3;
	logic [8:0]  dif7;
	logic [7:0]  dif6;
	logic [4:0]  dif3;
	logic [15:0] prod;
	logic        cin;

	// Carries and borrows at bits 3, 6 and 7 come from narrow partial sums.
	always_comb begin
		cin  = (op_i == SFP_OP_ADD) ? 1'b0 : carry_i;
		sum7 = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
		sum6 = {1'b0, acc_i[6:0]} + {1'b0, opnd_i[6:0]} + {7'h00, cin};
		sum3 = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
		dif7 = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, carry_i};
		dif6 = {1'b0, acc_i[6:0]} - {1'b0, opnd_i[6:0]} - {7'h00, carry_i};
		dif3 = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, carry_i};
		prod = {8'h00, acc_i} * {8'h00, opnd_i};
	end

	// Flag results per operation; anything else leaves the flags alone.
	always_comb begin
		upd_carry_o = 1'b0;
		upd_aux_o   = 1'b0;
		upd_ovf_o   = 1'b0;
		carry_o     = carry_i;
		aux_o       = 1'b0;
		ovf_o       = 1'b0;
		unique case (op_i)
			SFP_OP_ADD, SFP_OP_ADDC: begin
				upd_carry_o = 1'b1;
				upd_aux_o   = 1'b1;
				upd_ovf_o   = 1'b1;
				carry_o     = sum7[8];
				aux_o       = sum3[4];
				ovf_o       = sum7[8] ^ sum6[7];
			end
			SFP_OP_SUBB: begin
				upd_carry_o = 1'b1;
				upd_aux_o   = 1'b1;
				upd_ovf_o   = 1'b1;
				carry_o     = dif7[8];
				aux_o       = dif3[4];
				ovf_o       = dif7[8] ^ dif6[7];
			end
			SFP_OP_MUL: begin
				upd_carry_o = 1'b1;
				upd_ovf_o   = 1'b1;
				carry_o     = 1'b0;
				ovf_o       = (prod[15:8] != 8'h00);
			end
			SFP_OP_DIV: begin
				upd_carry_o = 1'b1;
				upd_ovf_o   = 1'b1;
				carry_o     = 1'b0;
				ovf_o       = (divisor_i == 8'h00);
			end
			SFP_OP_SETC: begin
				upd_carry_o = 1'b1;
				carry_o     = 1'b1;
			end
			SFP_OP_CLRC: begin
				upd_carry_o = 1'b1;
				carry_o     = 1'b0;
			end
			default: begin
			end
		endcase
	end

endmodule : sfp_arith_flags

// *** verilog/sfp_data_pointer_bank.sv ***
// Two data pointers; only the selected one is seen or written.
module sfp_pointer_bank
	import sfp_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        sel_i,
	input  wire logic        wr_lo_i,
	input  wire logic        wr_hi_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        ld_i,
	input  wire logic [15:0] ld_val_i,
	output logic [15:0]      ptr_o
);

	logic [15:0] ptr_q [2];
	logic [15:0] ptr_d [2];

	// Writes steer only the selected pointer, the other holds.
	always_comb begin
		ptr_d = ptr_q;
		if (ld_i) begin
			ptr_d[sel_i] = ld_val_i;
		end
		if (wr_lo_i) begin
			ptr_d[sel_i][7:0] = wdata_i;
		end
		if (wr_hi_i) begin
			ptr_d[sel_i][15:8] = wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			ptr_q[0] <= SFP_RST_PTR;
			ptr_q[1] <= SFP_RST_PTR;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	assign ptr_o = ptr_q[sel_i];

endmodule : sfp_pointer_bank

// *** verilog/sfp_status_flags.sv ***
// Chosen here: the strobed register port.
module sfp_status_flags
	import sfp_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire sfp_op_e     op_i,
	input  wire logic [7:0]  acc_i,
	input  wire logic [7:0]  opnd_i,
	input  wire logic [7:0]  divisor_i,
	input  wire logic        carry_val_i,
	input  wire logic        ptr_load_i,
	input  wire logic [15:0] ptr_load_val_i,
	output logic [7:0]       rdata_o,
	output logic [4:0]       bank_base_o,
	output logic             carry_flag_o,
	output logic [15:0]      data_pointer_o,
	output logic             pointer_select_o
);

	// Stored status bits; parity is not stored, it follows the accumulator.
	logic        carry_flag_q;
	logic        carry_flag_d;
	logic        aux_carry_flag_q;
	logic        aux_carry_flag_d;
	logic        user_flag_zero_q;
	logic        user_flag_zero_d;
	logic [1:0]  bank_select_q;
	logic [1:0]  bank_select_d;
	logic        overflow_flag_q;
	logic        overflow_flag_d;
	logic        user_flag_one_q;
	logic        user_flag_one_d;

	// Power control flags, the pointer select bit and read data.
	logic        general_flag_one_q;
	logic        general_flag_one_d;
	logic        general_flag_zero_q;
	logic        general_flag_zero_d;
	logic        pointer_select_q;
	logic        pointer_select_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	// Results from the arithmetic flag evaluator.
	logic        upd_carry;
	logic        upd_aux;
	logic        upd_ovf;
	logic        alu_carry;
	logic        alu_aux;
	logic        alu_ovf;

	// Register decode, live views and the selected pointer.
	logic        parity;
	logic        carry_load;
	logic        wr_status;
	logic        wr_pwr;
	logic        wr_aux1;
	logic        wr_ptr_lo;
	logic        wr_ptr_hi;
	logic [7:0]  status_view;
	logic [7:0]  pwr_view;
	logic [7:0]  aux1_view;
	logic [15:0] ptr_sel_val;

	// Odd number of ones gives 1; a function since it reads a whole byte.
	function automatic logic odd_parity(input logic [7:0] v);
		odd_parity = ^v;
	endfunction : odd_parity

	// Bank base address is the bank number times eight.
	function automatic logic [4:0] bank_base(input logic [1:0] bank);
		bank_base = SFP_BANK_BASE | {bank, 3'b000};
	endfunction : bank_base

	// A strobe and an offset make a register hit; every write decode uses it.
	function automatic logic reg_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		reg_hit = strobe && (addr == offset);
	endfunction : reg_hit

	// Flag arithmetic is kept apart so it can be checked on its own.
	sfp_arith_flags u_arith (
		.op_i        (op_i),
		.acc_i       (acc_i),
		.opnd_i      (opnd_i),
		.carry_i     (carry_flag_q),
		.divisor_i   (divisor_i),
		.upd_carry_o (upd_carry),
		.upd_aux_o   (upd_aux),
		.upd_ovf_o   (upd_ovf),
		.carry_o     (alu_carry),
		.aux_o       (alu_aux),
		.ovf_o       (alu_ovf)
	);

	// Both pointers live here; only the selected one is ever touched.
	sfp_pointer_bank u_ptr (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.sel_i     (pointer_select_q),
		.wr_lo_i   (wr_ptr_lo),
		.wr_hi_i   (wr_ptr_hi),
		.wdata_i   (wdata_i),
		.ld_i      (ptr_load_i),
		.ld_val_i  (ptr_load_val_i),
		.ptr_o     (ptr_sel_val)
	);

	// Register write decode.
	assign wr_status = reg_hit(wr_i, addr_i, SFP_ADDR_STATUS);
	assign wr_pwr    = reg_hit(wr_i, addr_i, SFP_ADDR_PWR_CTRL);
	assign wr_aux1   = reg_hit(wr_i, addr_i, SFP_ADDR_AUX1);
	assign wr_ptr_lo = reg_hit(wr_i, addr_i, SFP_ADDR_DPL);
	assign wr_ptr_hi = reg_hit(wr_i, addr_i, SFP_ADDR_DPH);

	// Parity is combinational so a read never shows a stale accumulator.
	assign parity = odd_parity(acc_i);

	// Bit operations, rotates, compares and decimal adjust compute their
	// carry in the core; this block only stores it.
	assign carry_load = (op_i == SFP_OP_CARRY) || (op_i == SFP_OP_DA);

	// Status word as software sees it.
	always_comb begin
		status_view                                = 8'h00;
		status_view[SFP_ST_CARRY]                  = carry_flag_q;
		status_view[SFP_ST_AUX]                    = aux_carry_flag_q;
		status_view[SFP_ST_USER0]                  = user_flag_zero_q;
		status_view[SFP_ST_BANK_HI:SFP_ST_BANK_LO] = bank_select_q;
		status_view[SFP_ST_OVF]                    = overflow_flag_q;
		status_view[SFP_ST_USER1]                  = user_flag_one_q;
		status_view[SFP_ST_PAR]                    = parity;
	end

	// Power control as seen here; its other bits belong to other blocks.
	always_comb begin
		pwr_view                  = 8'h00;
		pwr_view[SFP_PWR_FLAG_HI] = general_flag_one_q;
		pwr_view[SFP_PWR_FLAG_LO] = general_flag_zero_q;
	end

	// Select register view; bit 1 and the upper bits always read zero.
	always_comb begin
		aux1_view               = 8'h00;
		aux1_view[SFP_AUX1_SEL] = pointer_select_q;
	end

	// Status word next state. A core flag update in the same cycle as a
	// software write wins, because the instruction's result is newer.
	always_comb begin
		carry_flag_d     = carry_flag_q;
		aux_carry_flag_d = aux_carry_flag_q;
		user_flag_zero_d = user_flag_zero_q;
		bank_select_d    = bank_select_q;
		overflow_flag_d  = overflow_flag_q;
		user_flag_one_d  = user_flag_one_q;
		if (wr_status) begin
			carry_flag_d     = wdata_i[SFP_ST_CARRY];
			aux_carry_flag_d = wdata_i[SFP_ST_AUX];
			user_flag_zero_d = wdata_i[SFP_ST_USER0];
			bank_select_d    = wdata_i[SFP_ST_BANK_HI:SFP_ST_BANK_LO];
			overflow_flag_d  = wdata_i[SFP_ST_OVF];
			user_flag_one_d  = wdata_i[SFP_ST_USER1];
		end
		if (carry_load) begin
			carry_flag_d = carry_val_i;
		end
		if (upd_carry) begin
			carry_flag_d = alu_carry;
		end
		if (upd_aux) begin
			aux_carry_flag_d = alu_aux;
		end
		if (upd_ovf) begin
			overflow_flag_d = alu_ovf;
		end
	end

	// Status word registers.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			carry_flag_q     <= SFP_RST_STATUS[SFP_ST_CARRY];
			aux_carry_flag_q <= SFP_RST_STATUS[SFP_ST_AUX];
			user_flag_zero_q <= SFP_RST_STATUS[SFP_ST_USER0];
			bank_select_q    <= SFP_RST_STATUS[SFP_ST_BANK_HI:SFP_ST_BANK_LO];
			overflow_flag_q  <= SFP_RST_STATUS[SFP_ST_OVF];
			user_flag_one_q  <= SFP_RST_STATUS[SFP_ST_USER1];
		end else begin
			carry_flag_q     <= carry_flag_d;
			aux_carry_flag_q <= aux_carry_flag_d;
			user_flag_zero_q <= user_flag_zero_d;
			bank_select_q    <= bank_select_d;
			overflow_flag_q  <= overflow_flag_d;
			user_flag_one_q  <= user_flag_one_d;
		end
	end

	// General flags only change by a software write.
	always_comb begin
		general_flag_one_d  = general_flag_one_q;
		general_flag_zero_d = general_flag_zero_q;
		if (wr_pwr) begin
			general_flag_one_d  = wdata_i[SFP_PWR_FLAG_HI];
			general_flag_zero_d = wdata_i[SFP_PWR_FLAG_LO];
		end
	end

	// General flag registers.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			general_flag_one_q  <= SFP_RST_GF[1];
			general_flag_zero_q <= SFP_RST_GF[0];
		end else begin
			general_flag_one_q  <= general_flag_one_d;
			general_flag_zero_q <= general_flag_zero_d;
		end
	end

	// Only bit 0 of the select register is stored; the rest is dropped.
	always_comb begin
		pointer_select_d = pointer_select_q;
		if (wr_aux1) begin
			pointer_select_d = wdata_i[SFP_AUX1_SEL];
		end
	end

	// Select register.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			pointer_select_q <= SFP_RST_SEL;
		end else begin
			pointer_select_q <= pointer_select_d;
		end
	end

	// Read data stands in the cycle after the read strobe only, so a
	// master that misses that cycle sees zero rather than old data.
	always_comb begin
		rdata_d = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				SFP_ADDR_STATUS:   rdata_d = status_view;
				SFP_ADDR_PWR_CTRL: rdata_d = pwr_view;
				SFP_ADDR_AUX1:     rdata_d = aux1_view;
				SFP_ADDR_DPL:      rdata_d = ptr_sel_val[7:0];
				SFP_ADDR_DPH:      rdata_d = ptr_sel_val[15:8];
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs to the rest of the core.
	assign rdata_o          = rdata_q;
	assign bank_base_o      = bank_base(bank_select_q);
	assign carry_flag_o     = carry_flag_q;
	assign data_pointer_o   = ptr_sel_val;
	assign pointer_select_o = pointer_select_q;

endmodule : sfp_status_flags

// *** tb/sfp_status_flags_assertions.sv ***
module sfp_status_flags_chk
	import sfp_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire sfp_op_e     op_i,
	input wire logic [7:0]  acc_i,
	input wire logic [7:0]  opnd_i,
	input wire logic [7:0]  divisor_i,
	input wire logic        carry_val_i,
	input wire logic        ptr_load_i,
	input wire logic [15:0] ptr_load_val_i,
	input wire logic [7:0]  rdata_o,
	input wire logic [4:0]  bank_base_o,
	input wire logic        carry_flag_o,
	input wire logic [15:0] data_pointer_o,
	input wire logic        pointer_select_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] add_s;
	logic [8:0] sub_s;
	logic       acc_par;

	// Reference sums; the carry flag must follow them one cycle later.
	assign add_s = {1'b0, acc_i} + {1'b0, opnd_i};
	assign sub_s = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, carry_flag_o};
	assign acc_par = ^acc_i;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence stat_read;
		rd_i && addr_i == SFP_ADDR_STATUS;
	endsequence
	sequence sel_read;
		rd_i && addr_i == SFP_ADDR_AUX1;
	endsequence

	chk_add_carry:
	assert property (op_i == SFP_OP_ADD |=> carry_flag_o == $past(add_s[8]))
		else $error("carry wrong after add");
	chk_subb_borrow:
	assert property (op_i == SFP_OP_SUBB |=> carry_flag_o == $past(sub_s[8]))
		else $error("carry wrong after subtract");
	chk_muldiv_clear:
	assert property (op_i inside {SFP_OP_MUL, SFP_OP_DIV} |=> !carry_flag_o)
		else $error("carry set after multiply or divide");
	chk_set_carry:
	assert property (op_i == SFP_OP_SETC |=> carry_flag_o)
		else $error("set carry failed");
	chk_clear_carry:
	assert property (op_i == SFP_OP_CLRC |-> ##1 !carry_flag_o)
		else $error("clear carry failed");
	chk_idle_hold:
	assert property (op_i == SFP_OP_NONE
		&& !(wr_i && addr_i == SFP_ADDR_STATUS)
		|=> $stable(carry_flag_o)) else $error("carry moved while idle");
	chk_bank_map:
	assert property (wr_i && addr_i == SFP_ADDR_STATUS
		|=> bank_base_o == {$past(wdata_i[SFP_ST_BANK_HI:SFP_ST_BANK_LO]), 3'h0})
		else $error("bank base wrong");
	chk_select_write:
	assert property (wr_i && addr_i == SFP_ADDR_AUX1
		|=> pointer_select_o == $past(wdata_i[SFP_AUX1_SEL]))
		else $error("select wrong");
	chk_parity_read:
	assert property (stat_read |=> rdata_o[0] == $past(acc_par))
		else $error("parity wrong");
	chk_select_read:
	assert property (sel_read |=> rdata_o == {7'h00, pointer_select_o})
		else $error("select register read wrong");
	chk_read_idle:
	assert property (!rd_i |=> rdata_o == 8'h00) else $error("stray read data");
	chk_data_pointer_load:
	assert property (ptr_load_i && !wr_i
		|=> data_pointer_o == $past(ptr_load_val_i))
		else $error("pointer load wrong");
endmodule : sfp_status_flags_chk

// *** tb/tb.sv ***
module tb
	import sfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, acc_i = 8'h00;
	logic [7:0]  opnd_i = 8'h00, divisor_i = 8'h00;
	logic        wr_i = 1'b0, rd_i = 1'b0, carry_val_i = 1'b0;
	logic        ptr_load_i = 1'b0;
	logic [15:0] ptr_load_val_i = 16'h0000;
	sfp_op_e     op_i = SFP_OP_NONE;
	logic [7:0]  rdata_o;
	logic [4:0]  bank_base_o;
	logic        carry_flag_o, pointer_select_o;
	logic [15:0] data_pointer_o;
	logic [7:0]  m = 8'h00;
	logic [7:0]  q[$];
	logic        pend = 1'b0;
	int          err_total = 0, samples_checked = 0;
	logic [7:0]  ad [6] = '{SFP_ADDR_STATUS, SFP_ADDR_PWR_CTRL,
		SFP_ADDR_AUX1, SFP_ADDR_DPL, SFP_ADDR_DPH, 8'h55};

	sfp_status_flags sfp_status_flags_inst (
		.mclk_i           (mclk_i),
		.reset_n_i        (reset_n_i),
		.addr_i           (addr_i),
		.wdata_i          (wdata_i),
		.wr_i             (wr_i),
		.rd_i             (rd_i),
		.op_i             (op_i),
		.acc_i            (acc_i),
		.opnd_i           (opnd_i),
		.divisor_i        (divisor_i),
		.carry_val_i      (carry_val_i),
		.ptr_load_i       (ptr_load_i),
		.ptr_load_val_i   (ptr_load_val_i),
		.rdata_o          (rdata_o),
		.bank_base_o      (bank_base_o),
		.carry_flag_o     (carry_flag_o),
		.data_pointer_o   (data_pointer_o),
		.pointer_select_o (pointer_select_o)
	);

	// Core clock at 10 MHz.
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// One bus cycle; every call replaces the last, so strobes stay one cycle.
	task automatic cyc(input logic w, r, input logic [7:0] a, d);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
		op_i <= SFP_OP_NONE;
		ptr_load_i <= 1'b0;
	endtask : cyc

	task automatic wr(input logic [7:0] a, d);
		cyc(1'b1, 1'b0, a, d);
		if (a == SFP_ADDR_STATUS)
			m = {d[7:1], m[0]};
	endtask : wr

	// The expected answer is queued now and judged by the monitor.
	task automatic rd(input logic [7:0] a, e);
		cyc(1'b0, 1'b1, a, 8'h00);
		q.push_back(e);
	endtask : rd

	// Presents one operation and advances the flag model with it.
	task automatic do_op(input sfp_op_e o, input logic [7:0] x, y, dv,
		input logic cv);
		logic [8:0]  s;
		logic [7:0]  t;
		logic [4:0]  u;
		logic [15:0] p;
		logic        ci;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		op_i <= o;
		acc_i <= x;
		opnd_i <= y;
		divisor_i <= dv;
		carry_val_i <= cv;
		ci = (o != SFP_OP_ADD) & m[7];
		p = {8'h00, x} * {8'h00, y};
		if (o == SFP_OP_SUBB) begin
			s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
			t = {1'b0, x[6:0]} - {1'b0, y[6:0]} - {7'h00, ci};
			u = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
		end else begin
			s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
			t = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, ci};
			u = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
		end
		m[0] = ^x;
		case (o)
			SFP_OP_ADD, SFP_OP_ADDC, SFP_OP_SUBB: begin
				m[7] = s[8];
				m[6] = u[4];
				m[2] = s[8] ^ t[7];
			end
			SFP_OP_MUL: m[7:2] = {1'b0, m[6:3], |p[15:8]};
			SFP_OP_DIV: m[7:2] = {1'b0, m[6:3], dv == 8'h00};
			SFP_OP_DA, SFP_OP_CARRY: m[7] = cv;
			SFP_OP_SETC: m[7] = 1'b1;
			SFP_OP_CLRC: m[7] = 1'b0;
			default: ;
		endcase
	endtask : do_op

	// Read data stand one cycle late; judge them mid-cycle once settled.
	always @(posedge mclk_i) begin
		pend <= rd_i;
	end
	always @(negedge mclk_i) begin
		if (pend) begin
			samples_checked++;
			if (rdata_o !== q.pop_front()) begin
				err_total++;
				$display("mismatch at %0t: read data %h", $time, rdata_o);
			end
		end
	end

	// The tests need under a thousand cycles; cut a hang off well after.
	initial begin
		repeat (4000) @(posedge mclk_i);
		err_total++;
		$display("mismatch at %0t: run did not finish", $time);
		finish_test();
	end

	initial begin
		logic [7:0] v;
		void'($urandom(98564));
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		foreach (ad[i]) rd(ad[i], 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom());
			v[4:3] = 2'(i);
			wr(SFP_ADDR_STATUS, v);
			rd(SFP_ADDR_STATUS, m);
		end
		wr(SFP_ADDR_PWR_CTRL, 8'hff);
		rd(SFP_ADDR_PWR_CTRL, 8'h0c);
		wr(SFP_ADDR_PWR_CTRL, 8'h04);
		rd(SFP_ADDR_PWR_CTRL, 8'h04);
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h00);
		wr(SFP_ADDR_AUX1, 8'hff);
		rd(SFP_ADDR_AUX1, 8'h01);
		wr(SFP_ADDR_DPL, 8'h12);
		wr(SFP_ADDR_DPH, 8'h34);
		wr(SFP_ADDR_AUX1, 8'hfe);
		rd(SFP_ADDR_AUX1, 8'h00);
		rd(SFP_ADDR_DPH, 8'h00);
		wr(SFP_ADDR_DPL, 8'hab);
		wr(SFP_ADDR_AUX1, 8'h01);
		rd(SFP_ADDR_DPL, 8'h12);
		@(posedge mclk_i);
		rd_i <= 1'b0;
		ptr_load_i <= 1'b1;
		ptr_load_val_i <= 16'hbeef;
		rd(SFP_ADDR_DPH, 8'hbe);
		wr(SFP_ADDR_AUX1, 8'h00);
		rd(SFP_ADDR_DPL, 8'hab);
		do_op(SFP_OP_ADD, 8'h7f, 8'h01, 8'h01, 1'b0);
		rd(SFP_ADDR_STATUS, m);
		do_op(SFP_OP_SUBB, 8'h80, 8'h01, 8'h01, 1'b0);
		rd(SFP_ADDR_STATUS, m);
		do_op(SFP_OP_MUL, 8'h10, 8'h10, 8'h01, 1'b0);
		do_op(SFP_OP_MUL, 8'h0f, 8'h11, 8'h01, 1'b0);
		rd(SFP_ADDR_STATUS, m);
		do_op(SFP_OP_DIV, 8'h20, 8'h00, 8'h00, 1'b0);
		rd(SFP_ADDR_STATUS, m);
		for (int i = 0; i < 80; i++) begin
			v = 8'($urandom());
			do_op(sfp_op_e'(4'(i % 10)), 8'($urandom()), 8'($urandom()),
				(i % 20 < 10) ? 8'h00 : v, v[0]);
			rd(SFP_ADDR_STATUS, m);
		end
		finish_test();
	end
endmodule : tb

bind sfp_status_flags sfp_status_flags_chk sfp_status_flags_chk_inst (
	.mclk_i           (mclk_i),
	.reset_n_i        (reset_n_i),
	.addr_i           (addr_i),
	.wdata_i          (wdata_i),
	.wr_i             (wr_i),
	.rd_i             (rd_i),
	.op_i             (op_i),
	.acc_i            (acc_i),
	.opnd_i           (opnd_i),
	.divisor_i        (divisor_i),
	.carry_val_i      (carry_val_i),
	.ptr_load_i       (ptr_load_i),
	.ptr_load_val_i   (ptr_load_val_i),
	.rdata_o          (rdata_o),
	.bank_base_o      (bank_base_o),
	.carry_flag_o     (carry_flag_o),
	.data_pointer_o   (data_pointer_o),
	.pointer_select_o (pointer_select_o)
);
